// *** rtl/qbt_transceiver.sv ***
// Purpose: quad bus transceiver with AXI4-Lite register view
// Assumes: all pins synchronous to clk, bus wire resolved outside
// Notes: controls may come from pins or from software
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - four-bit register, per-bit two-word multiplexer
// - select low stores A, high stores B
// - register loads only on clock rise or software load
// - drive enable high floats all drivers
// - bus carries inverse of register bits
// - receivers invert bus, round trip non-inverted
// - receivers always see bus, own drive too
// - hold low makes latches follow bus
// - hold high keeps last received value
// - output enable high floats receiver outputs
// - driver and receiver controls act independently
module qbt_transceiver
    import qbt_pkg::*;
#(
    parameter int WIDTH = QBT_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] wordA,
    input wire logic [WIDTH-1:0] wordB,
    input wire logic wordSel,
    input wire logic driverRegClock,
    input wire logic busDriveEnableN,
    input wire logic receiverHold,
    input wire logic recvOutEnableN,
    input wire logic [WIDTH-1:0] busIn,
    output logic [WIDTH-1:0] busOut,
    output logic [WIDTH-1:0] busOe,
    output logic [WIDTH-1:0] recvOut,
    output logic [WIDTH-1:0] recvOe,
    input wire logic [QBT_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [QBT_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [QBT_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [QBT_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // status packs each word into one byte
    if (WIDTH < 1 || WIDTH > 8) begin : gWidthCheck
        $error("qbt_transceiver: WIDTH must be 1 to 8");
    end

    // ---------------- register state ----------------
    logic [7:0] ctrl_r;
    logic [WIDTH-1:0] swWordA_r;
    logic [WIDTH-1:0] swWordB_r;
    logic [1:0] event_r;
    logic [1:0] event_nxt;
    logic [7:0] loadCnt_r;
    logic swLoad_r;
    logic drvClkPrev_r;

    // write channel holding
    logic awHeld_r;
    logic wHeld_r;
    logic [QBT_ADDR_W-1:0] awAddr_r;
    logic [QBT_DATA_W-1:0] wData_r;
    logic [3:0] wStrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    // read channel
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [QBT_DATA_W-1:0] rdata_r;

    // ---------------- control selection ----------------
    // software may take over the control pins as a group
    wire swCtrl = ctrl_r[QBT_CTRL_SWCTRL];
    wire swWords = ctrl_r[QBT_CTRL_SWWORDS];
    wire selEff = swCtrl ? ctrl_r[QBT_CTRL_SEL] : wordSel;
    wire drvEnNEff = swCtrl ? ctrl_r[QBT_CTRL_DRVN] : busDriveEnableN;
    wire holdEff = swCtrl ? ctrl_r[QBT_CTRL_HOLD] : receiverHold;
    wire outEnNEff = swCtrl ? ctrl_r[QBT_CTRL_OUTN] : recvOutEnableN;
    wire [WIDTH-1:0] srcA = swWords ? swWordA_r : wordA;
    wire [WIDTH-1:0] srcB = swWords ? swWordB_r : wordB;

    // clock rise seen as a pulse; steady levels load nothing
    wire drvClkRise = driverRegClock && !drvClkPrev_r;
    wire loadPulse = drvClkRise || swLoad_r;

    // ---------------- datapath ----------------
    wire [WIDTH-1:0] driverQ;
    wire [WIDTH-1:0] rxQ;
    wire rxChanged;

    qbt_drv_reg #(
        .WIDTH(WIDTH)
    ) uDrvReg (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .load(loadPulse),
        .sel(selEff),
        .wordA(srcA),
        .wordB(srcB),
        .q(driverQ)
    );

    wire driving = !drvEnNEff;
    wire [WIDTH-1:0] busDrive = ~driverQ;
    // own drive taken straight back; another driver at the same time
    // is a bus fault that the far side must prevent
    wire [WIDTH-1:0] busSeen = driving ? busDrive : busIn;

    qbt_rx_latch #(
        .WIDTH(WIDTH)
    ) uRxLatch (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .hold(holdEff),
        .busLevel(busSeen),
        .q(rxQ),
        .changed(rxChanged)
    );

    assign busOut = busDrive;
    assign busOe = {WIDTH{driving}};
    assign recvOut = rxQ;
    assign recvOe = {WIDTH{!outEnNEff}};

    // ---------------- write channel ----------------
    assign awready = ce && !awHeld_r && !bvalid_r;
    assign wready = ce && !wHeld_r && !bvalid_r;
    wire awTake = awvalid && awready;
    wire wTake = wvalid && wready;
    wire haveAw = awHeld_r || awTake;
    wire haveW = wHeld_r || wTake;
    wire doWrite = ce && haveAw && haveW && !bvalid_r;

    wire [QBT_ADDR_W-1:0] wrAddr = awHeld_r ? awAddr_r : awaddr;
    wire [QBT_DATA_W-1:0] wrData = wHeld_r ? wData_r : wdata;
    wire [3:0] wrStrb = wHeld_r ? wStrb_r : wstrb;
    wire wrByte0 = doWrite && wrStrb[0];

    wire wHitCtrl = qbt_hit(wrAddr, QBT_OFS_CTRL);
    wire wHitA = qbt_hit(wrAddr, QBT_OFS_WORD_A);
    wire wHitB = qbt_hit(wrAddr, QBT_OFS_WORD_B);
    wire wHitEvt = qbt_hit(wrAddr, QBT_OFS_EVENT);
    // status and load count are read-only; writes there are errors
    wire wMapped = wHitCtrl || wHitA || wHitB || wHitEvt;

    wire ctrlWr = wrByte0 && wHitCtrl;
    wire wordAWr = wrByte0 && wHitA;
    wire wordBWr = wrByte0 && wHitB;
    wire evtWr = wrByte0 && wHitEvt;
    wire [1:0] evtClr = evtWr ? wrData[1:0] : 2'h0;
    wire [1:0] evtSet = {rxChanged, ce && loadPulse};

    // set beats clear in the same cycle
    always_comb begin
        event_nxt = (event_r & ~evtClr) | evtSet;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (ce) begin
            if (doWrite) begin
                awHeld_r <= 1'b0;
            end else if (awTake) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= 4'h0;
        end else if (ce) begin
            if (doWrite) begin
                wHeld_r <= 1'b0;
            end else if (wTake) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bvalid_r <= 1'b0;
            bresp_r <= QBT_RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                bvalid_r <= 1'b1;
                bresp_r <= wMapped ? QBT_RESP_OKAY : QBT_RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // ---------------- register updates ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= QBT_CTRL_RST;
            swLoad_r <= 1'b0;
        end else if (ce) begin
            swLoad_r <= ctrlWr && wrData[QBT_CTRL_SWLOAD];
            if (ctrlWr) begin
                ctrl_r <= wrData[7:0] & QBT_CTRL_WMASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            swWordA_r <= QBT_DATA_RST[WIDTH-1:0];
            swWordB_r <= QBT_DATA_RST[WIDTH-1:0];
        end else if (ce) begin
            if (wordAWr) begin
                swWordA_r <= wrData[WIDTH-1:0];
            end
            if (wordBWr) begin
                swWordB_r <= wrData[WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            drvClkPrev_r <= 1'b0;
            event_r <= 2'h0;
            loadCnt_r <= QBT_CNT_RST;
        end else if (ce) begin
            drvClkPrev_r <= driverRegClock;
            event_r <= event_nxt;
            if (loadPulse) begin
                loadCnt_r <= loadCnt_r + 8'h01;
            end
        end
    end

    // ---------------- read channel ----------------
    assign arready = ce && !rvalid_r;
    wire arTake = arvalid && arready;

    wire rHitCtrl = qbt_hit(araddr, QBT_OFS_CTRL);
    wire rHitA = qbt_hit(araddr, QBT_OFS_WORD_A);
    wire rHitB = qbt_hit(araddr, QBT_OFS_WORD_B);
    wire rHitSt = qbt_hit(araddr, QBT_OFS_STATUS);
    wire rHitEvt = qbt_hit(araddr, QBT_OFS_EVENT);
    wire rHitCnt = qbt_hit(araddr, QBT_OFS_LOADCNT);
    wire rMapped = rHitCtrl || rHitA || rHitB || rHitSt || rHitEvt
        || rHitCnt;

    logic [QBT_DATA_W-1:0] statusWord;
    always_comb begin
        statusWord = '0;
        statusWord[QBT_ST_DRV +: WIDTH] = driverQ;
        statusWord[QBT_ST_RX +: WIDTH] = rxQ;
        statusWord[QBT_ST_BUS +: WIDTH] = busSeen;
        statusWord[QBT_ST_DRIVING] = driving;
        statusWord[QBT_ST_HOLDING] = holdEff;
        statusWord[QBT_ST_ROUT] = !outEnNEff;
    end

    wire [QBT_DATA_W-1:0] rdCtrl = {24'h000000, ctrl_r};
    wire [QBT_DATA_W-1:0] rdA = {{(QBT_DATA_W-WIDTH){1'b0}}, swWordA_r};
    wire [QBT_DATA_W-1:0] rdB = {{(QBT_DATA_W-WIDTH){1'b0}}, swWordB_r};
    wire [QBT_DATA_W-1:0] rdEvt = {30'h00000000, event_r};
    wire [QBT_DATA_W-1:0] rdCnt = {24'h000000, loadCnt_r};
    wire [QBT_DATA_W-1:0] rdMux =
        rHitCtrl ? rdCtrl :
        rHitA ? rdA :
        rHitB ? rdB :
        rHitSt ? statusWord :
        rHitEvt ? rdEvt :
        rHitCnt ? rdCnt : '0;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rresp_r <= QBT_RESP_OKAY;
            rdata_r <= '0;
        end else if (ce) begin
            if (arTake) begin
                rvalid_r <= 1'b1;
                rdata_r <= rdMux;
                rresp_r <= rMapped ? QBT_RESP_OKAY : QBT_RESP_SLVERR;
            end else if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
endmodule : qbt_transceiver
`default_nettype wire

// *** rtl/qbt_pkg.sv ***
// Purpose: shared constants for the quad bus transceiver
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: word A and B registers hold narrow data in their low bits
package qbt_pkg;
    localparam int QBT_WIDTH = 4;
    localparam int QBT_ADDR_W = 8;
    localparam int QBT_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] QBT_OFS_CTRL = 8'h00;
    localparam logic [7:0] QBT_OFS_WORD_A = 8'h04;
    localparam logic [7:0] QBT_OFS_WORD_B = 8'h08;
    localparam logic [7:0] QBT_OFS_STATUS = 8'h0C;
    localparam logic [7:0] QBT_OFS_EVENT = 8'h10;
    localparam logic [7:0] QBT_OFS_LOADCNT = 8'h14;

    // control register fields
    localparam int QBT_CTRL_SWWORDS = 0;
    localparam int QBT_CTRL_SWLOAD = 1;
    localparam int QBT_CTRL_SWCTRL = 2;
    localparam int QBT_CTRL_SEL = 4;
    localparam int QBT_CTRL_DRVN = 5;
    localparam int QBT_CTRL_HOLD = 6;
    localparam int QBT_CTRL_OUTN = 7;
    localparam logic [7:0] QBT_CTRL_RST = 8'h00;
    localparam logic [7:0] QBT_CTRL_WMASK = 8'hF5;

    // event register fields
    localparam int QBT_EVT_LOAD = 0;
    localparam int QBT_EVT_RXCHG = 1;

    // status register fields
    localparam int QBT_ST_DRV = 0;
    localparam int QBT_ST_RX = 8;
    localparam int QBT_ST_BUS = 16;
    localparam int QBT_ST_DRIVING = 24;
    localparam int QBT_ST_HOLDING = 25;
    localparam int QBT_ST_ROUT = 26;

    localparam logic [7:0] QBT_DATA_RST = 8'h00;
    localparam logic [7:0] QBT_CNT_RST = 8'h00;

    localparam logic [1:0] QBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] QBT_RESP_SLVERR = 2'h2;

    // word-aligned hit test, shared by read and write decode
    function automatic logic qbt_hit(
        input logic [QBT_ADDR_W-1:0] addr,
        input logic [7:0] ofs);
        qbt_hit = (addr[QBT_ADDR_W-1:2] == ofs[QBT_ADDR_W-1:2]);
    endfunction : qbt_hit
endpackage : qbt_pkg

// *** rtl/qbt_drv_reg.sv ***
// Purpose: driver register with per-bit two-word multiplexer
// Assumes: load is a one-cycle pulse standing for a clock rise
// Notes: value holds between loads
`timescale 1ns/1ps
`default_nettype none
module qbt_drv_reg
    import qbt_pkg::*;
#(
    parameter int WIDTH = QBT_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic sel,
    input wire logic [WIDTH-1:0] wordA,
    input wire logic [WIDTH-1:0] wordB,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_r;
    wire [WIDTH-1:0] muxWord = sel ? wordB : wordA;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_r <= QBT_DATA_RST[WIDTH-1:0];
        end else if (ce && load) begin
            q_r <= muxWord;
        end
    end

    assign q = q_r;
endmodule : qbt_drv_reg
`default_nettype wire

// *** rtl/qbt_rx_latch.sv ***
// Purpose: inverting receivers feeding holdable latches
// Assumes: bus level already resolved, own drive included
// Notes: transparency costs one clock of latency
`timescale 1ns/1ps
`default_nettype none
module qbt_rx_latch
    import qbt_pkg::*;
#(
    parameter int WIDTH = QBT_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hold,
    input wire logic [WIDTH-1:0] busLevel,
    output logic [WIDTH-1:0] q,
    output logic changed
);
    logic [WIDTH-1:0] q_r;
    wire [WIDTH-1:0] rxWord = ~busLevel;
    wire openUpdate = ce && !hold && (rxWord != q_r);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_r <= QBT_DATA_RST[WIDTH-1:0];
        end else if (ce && !hold) begin
            q_r <= rxWord;
        end
    end

    assign q = q_r;
    assign changed = openUpdate;
endmodule : qbt_rx_latch
`default_nettype wire

// *** verification/qbt_transceiver_asserts.sv ***
// Purpose: port-level checks for the quad bus transceiver
// Assumes: pins steer the datapath, software never takes the pins
// Notes: bound into every qbt_transceiver instance
`timescale 1ns/1ps
`default_nettype none
module qbt_transceiver_asserts
    import qbt_pkg::*;
#(
    parameter int WIDTH = QBT_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] wordA,
    input wire logic [WIDTH-1:0] wordB,
    input wire logic wordSel,
    input wire logic driverRegClock,
    input wire logic busDriveEnableN,
    input wire logic receiverHold,
    input wire logic recvOutEnableN,
    input wire logic [WIDTH-1:0] busIn,
    input wire logic [WIDTH-1:0] busOut,
    input wire logic [WIDTH-1:0] busOe,
    input wire logic [WIDTH-1:0] recvOut,
    input wire logic [WIDTH-1:0] recvOe,
    input wire logic awready,
    input wire logic wready,
    input wire logic arready
);
    logic prevClk_r;
    wire loadNow = ce && driverRegClock && !prevClk_r;
    // own drive wins over the wire while enabled
    wire [WIDTH-1:0] seen = (busOe & busOut) | (~busOe & busIn);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prevClk_r <= 1'b0;
        end else if (ce) begin
            prevClk_r <= driverRegClock;
        end
    end
    chk_drive_gate: assert property (busOe == {WIDTH{!busDriveEnableN}})
        else $error("bus drive enable not followed");
    chk_out_gate: assert property (recvOe == {WIDTH{!recvOutEnableN}})
        else $error("receiver output enable not followed");
    chk_load_word: assert property (loadNow |=>
        busOut == ($past(wordSel) ? ~$past(wordB) : ~$past(wordA)))
        else $error("loaded word wrong on bus");
    chk_reg_steady: assert property (ce && !loadNow |=> $stable(busOut))
        else $error("driver register moved without clock rise");
    chk_rx_follow: assert property (ce && !receiverHold |=>
        recvOut == ~$past(seen))
        else $error("receiver does not follow bus");
    chk_rx_hold: assert property (
        ce && receiverHold |=> $stable(recvOut))
        else $error("held receiver value changed");
    chk_ce_freeze: assert property (!ce |=> $stable(busOut) && $stable(recvOut))
        else $error("state moved while frozen");
    chk_ready_gate: assert property (!ce |-> !awready && !wready && !arready)
        else $error("ready offered while frozen");
endmodule : qbt_transceiver_asserts

bind qbt_transceiver qbt_transceiver_asserts #(.WIDTH(WIDTH)) u_chk (
    .clk(clk), .rstn(rstn), .ce(ce), .wordA(wordA), .wordB(wordB),
    .wordSel(wordSel), .driverRegClock(driverRegClock),
    .busDriveEnableN(busDriveEnableN), .receiverHold(receiverHold),
    .recvOutEnableN(recvOutEnableN), .busIn(busIn), .busOut(busOut),
    .busOe(busOe), .recvOut(recvOut), .recvOe(recvOe),
    .awready(awready), .wready(wready), .arready(arready)
);
`default_nettype wire

// *** verification/qbt_bus_peer.sv ***
// Purpose: another transceiver sharing the bus wire
// Assumes: no termination level, released wire is not trusted
// Notes: resolves the wire for the device's receiver input
`timescale 1ns/1ps
`default_nettype none
module qbt_bus_peer
    import qbt_pkg::*;
#(
    parameter int WIDTH = QBT_WIDTH
) (
    input wire logic clk,
    input wire logic peerEn,
    input wire logic [WIDTH-1:0] peerData,
    input wire logic [WIDTH-1:0] dutOe,
    input wire logic [WIDTH-1:0] dutOut,
    output logic [WIDTH-1:0] busLevel
);
    logic [WIDTH-1:0] last_r = '0;
    // backs off whenever the device drives, so no contention
    wire [WIDTH-1:0] peerOe = {WIDTH{peerEn}} & ~dutOe;
    // a floating wire toggles so a stale value cannot pass
    wire [WIDTH-1:0] floatLvl = ~last_r;
    assign busLevel = (dutOe & dutOut) | (peerOe & peerData)
        | (~dutOe & ~peerOe & floatLvl);
    always_ff @(posedge clk) begin
        last_r <= busLevel;
    end
endmodule : qbt_bus_peer
`default_nettype wire

// *** verification/qbt_transceiver_bench.sv ***
// Purpose: self-checking bench for the quad bus transceiver
// Assumes: pins steer the datapath, software control bits stay clear
// Notes: register answers are checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
module qbt_transceiver_bench
    import qbt_pkg::*;
;
    localparam int W = QBT_WIDTH;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [W-1:0] wordA = '0, wordB = '0, peerData = '0, v, w;
    logic wordSel = 0, driverRegClock = 0, busDriveEnableN = 1;
    logic receiverHold = 0, recvOutEnableN = 0, peerEn = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire [W-1:0] busIn, busOut, busOe, recvOut, recvOe;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    logic [34:0] expQ[$];
    int fail_count = 0, total_checks = 0, cycles = 0;
    integer seed = 32'hedd92a40;

    always #10 clk = ~clk;

    qbt_transceiver #(.WIDTH(W)) dut (
        .clk(clk), .rstn(rstn), .ce(ce), .wordA(wordA), .wordB(wordB),
        .wordSel(wordSel), .driverRegClock(driverRegClock),
        .busDriveEnableN(busDriveEnableN), .receiverHold(receiverHold),
        .recvOutEnableN(recvOutEnableN), .busIn(busIn), .busOut(busOut),
        .busOe(busOe), .recvOut(recvOut), .recvOe(recvOe),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    qbt_bus_peer #(.WIDTH(W)) u_peer (.clk(clk), .peerEn(peerEn),
        .peerData(peerData), .dutOe(busOe), .dutOut(busOut),
        .busLevel(busIn));

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t pin value %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic take(input logic [34:0] got);
        logic [34:0] exp;
        exp = expQ.pop_front();
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t answer %h want %h", $time, got, exp);
        end
    endtask : take

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        expQ.push_back({1'b0, r, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        expQ.push_back({1'b1, r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    // answers are taken at the handshake edge, oldest note first
    always @(posedge clk) begin
        if (bvalid && bready) take({1'b0, bresp, 32'h0});
        if (rvalid && rready) take({1'b1, rresp, rdata});
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(QBT_OFS_CTRL, 32'h0, QBT_RESP_OKAY);
        rd(QBT_OFS_WORD_A, 32'h0, QBT_RESP_OKAY);
        rd(QBT_OFS_LOADCNT, 32'h0, QBT_RESP_OKAY);
        wr(QBT_OFS_CTRL, 32'h10, QBT_RESP_OKAY);
        rd(QBT_OFS_CTRL, 32'h10, QBT_RESP_OKAY);
        wr(QBT_OFS_CTRL, 32'h0, QBT_RESP_OKAY);
        w = W'($random(seed));
        wr(QBT_OFS_WORD_B, {28'h0, w}, QBT_RESP_OKAY);
        rd(QBT_OFS_WORD_B, {28'h0, w}, QBT_RESP_OKAY);
        wr(QBT_OFS_STATUS, 32'hF, QBT_RESP_SLVERR);
        wr(8'h40, 32'hF, QBT_RESP_SLVERR);
        rd(8'h40, 32'h0, QBT_RESP_SLVERR);
        busDriveEnableN <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            v = W'($random(seed));
            w = W'($random(seed));
            wordA <= v;
            wordB <= w;
            wordSel <= s[0];
            tick(1);
            driverRegClock <= 1'b1;
            tick(3);
            if (s == 0) w = v;
            chk(busOut, ~w);
            chk(recvOut, w);
            chk(busOe, {W{1'b1}});
            wordA <= ~v;
            wordB <= ~wordB;
            tick(3);
            chk(busOut, ~w);
            driverRegClock <= 1'b0;
            tick(3);
            chk(busOut, ~w);
        end
        rd(QBT_OFS_STATUS, {8'h05, 4'h0, ~w, 4'h0, w, 4'h0, w},
           QBT_RESP_OKAY);
        rd(QBT_OFS_LOADCNT, 32'h2, QBT_RESP_OKAY);
        wr(QBT_OFS_LOADCNT, 32'h0, QBT_RESP_SLVERR);
        rd(QBT_OFS_EVENT, 32'h3, QBT_RESP_OKAY);
        wr(QBT_OFS_EVENT, 32'h3, QBT_RESP_OKAY);
        rd(QBT_OFS_EVENT, 32'h0, QBT_RESP_OKAY);
        v = W'($random(seed));
        busDriveEnableN <= 1'b1;
        peerEn <= 1'b1;
        peerData <= v;
        tick(3);
        chk(busOe, {W{1'b0}});
        chk(recvOut, ~v);
        receiverHold <= 1'b1;
        tick(1);
        peerData <= ~v;
        tick(3);
        chk(recvOut, ~v);
        peerEn <= 1'b0;
        busDriveEnableN <= 1'b0;
        recvOutEnableN <= 1'b1;
        tick(3);
        chk(recvOut, ~v);
        chk(recvOe, {W{1'b0}});
        receiverHold <= 1'b0;
        recvOutEnableN <= 1'b0;
        tick(3);
        chk(recvOut, w);
        chk(recvOe, {W{1'b1}});
        // a rise seen while frozen is taken once the clock enable returns
        ce <= 1'b0;
        wordA <= v;
        wordSel <= 1'b0;
        tick(2);
        driverRegClock <= 1'b1;
        tick(3);
        chk(busOut, ~w);
        ce <= 1'b1;
        tick(3);
        chk(busOut, ~v);
        test_done();
    end
endmodule : qbt_transceiver_bench
`default_nettype wire
